// ===== rtl/pls_led_driver.v
// LED status driver for a quad-port PHY: mode decode, animation, polarity and drive
// What this block does
// - Four polarity bits, one per LED position, select active level.
// - After reset every LED is active low.
// - Four LEDs per port, each with its own independent mode.
// - Pins not taken by serial mode keep working as normal LEDs.
// - Drive-state bit set: inactive tristated; cleared: inactive driven.
// - Enhanced serial mode always drives the inactive level, ignoring drive-state.
// - Each pin shows the function picked by its own mode code.
// - Activity and collision animate by blink or pulse-stretch per LED setting.
// - Mode 0: on with any link, animated with activity.
// - Modes 1-3: single speed class link with activity.
// - Modes 4-7: combined speed groups or fiber link with activity.
// - Mode 8: on at full duplex, animated on half-duplex collisions.
// - Mode 9: off, animated on collisions.
// - Mode 10: any activity, or transmit only when split bit set.
// - Mode 11: fiber activity, or receive activity when split bit set.
// - Mode 12: on while an autonegotiation fault exists.
// - Mode 13 is a serial stream on port 0, reserved elsewhere.
// - Modes 14/15 force off/on and suppress the after-reset blink.
`timescale 1ns/10ps
`default_nettype none
`include "pls_defines.vh"

module pls_led_driver #(
   parameter TICK_CYCLES = `PLS_TICK_NS / `PLS_CLK_NS
) (
   input wire clk,
   input wire rst,
   input wire [`PLS_ADDR_W-1:0] reg_addr,
   input wire [`PLS_DATA_W-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [`PLS_DATA_W-1:0] reg_rdata,
   input wire [3:0] link_up,
   input wire [7:0] link_speed,
   input wire [3:0] link_fiber,
   input wire [3:0] link_full_duplex,
   input wire [3:0] collision,
   input wire [3:0] tx_activity,
   input wire [3:0] rx_activity,
   input wire [3:0] aneg_fault,
   output reg [15:0] first_led_pin_group,
   output reg [15:0] led_oe
);

   localparam [31:0] TICK_LAST32 = TICK_CYCLES - 1;
   localparam [19:0] TICK_LAST = TICK_LAST32[19:0];

   // Result bit 1: steady state; bit 0: animate request
   function [1:0] led_fn;
      input [3:0] m;
      input lk;
      input [1:0] sp;
      input fb;
      input fd;
      input cl;
      input tx;
      input rx;
      input af;
      input split;
      input port0;
      reg act;
      reg g1000;
      reg g100;
      reg g10;
      reg gl;
      begin
         act = tx | rx;
         g1000 = lk & (sp == `PLS_SPD_1000);
         g100 = lk & (sp == `PLS_SPD_100);
         g10 = lk & (sp == `PLS_SPD_10) & ~fb;
         gl = 1'b0;
         led_fn = 2'b00;
         case (m)
            `PLS_M_LINK: begin
               gl = lk;
            end
            `PLS_M_L1000: begin
               gl = g1000;
            end
            `PLS_M_L100: begin
               gl = g100;
            end
            `PLS_M_L10: begin
               gl = g10;
            end
            `PLS_M_L100_1000: begin
               gl = g100 | g1000;
            end
            `PLS_M_L10_1000: begin
               gl = g10 | g1000;
            end
            `PLS_M_L10_100: begin
               gl = g10 | g100;
            end
            `PLS_M_LFIBER: begin
               gl = lk & fb & (g100 | g1000);
            end
            `PLS_M_DUPLEX: begin
               led_fn = {lk & fd, lk & ~fd & cl};
            end
            `PLS_M_COLL: begin
               led_fn = {1'b0, cl};
            end
            `PLS_M_ACT: begin
               led_fn = {1'b0, split ? tx : act};
            end
            `PLS_M_FACT: begin
               led_fn = {1'b0, split ? rx : (lk & fb & ~(sp == `PLS_SPD_10) & act)};
            end
            `PLS_M_ANFAULT: begin
               led_fn = {af, 1'b0};
            end
            `PLS_M_SERIAL: begin
               led_fn = 2'b00;
            end
            `PLS_M_OFF: begin
               led_fn = 2'b00;
            end
            default: begin
               led_fn = 2'b10;
            end
         endcase
         if (m <= `PLS_M_LFIBER) begin
            led_fn = {gl, gl & act};
         end
      end
   endfunction

   // Serial stream bit: steady state with blink applied
   function ser_one;
      input [1:0] fn;
      input bp;
      begin
         ser_one = fn[1] ^ (fn[0] & bp);
      end
   endfunction

   reg [15:0] mode_reg [0:3];
   reg [15:0] beh_reg [0:3];
   reg [15:0] pol_reg;
   reg [15:0] drive_reg;
   reg [15:0] misc_reg;
   reg [19:0] tick_cnt_reg;
   reg tick_reg;
   reg [9:0] blink_cnt_reg;
   reg blink_phase_reg;
   reg [9:0] rblink_cnt_reg;
   reg rblink_active_reg;
   reg [7:0] str_cnt_reg [0:15];
   reg [3:0] ser_div_reg;
   reg ser_clk_reg;
   reg [5:0] ser_idx_reg;
   reg [47:0] ser_sh_reg;
   reg [15:0] lit_reg;

   reg [15:0] out_next;
   reg [15:0] oe_next;
   reg [15:0] lit_next;
   reg [15:0] anim_next;
   reg [47:0] frame_next;
   reg [1:0] fn_v;
   reg [3:0] m_v;
   reg pol_v;
   reg lit_v;
   reg [11:0] sb_v;
   integer p;
   integer q;
   integer k;
   integer n;

   // Register port: writes steer the block, unmapped reads return zero
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         for (k = 0; k < 4; k = k + 1) begin
            mode_reg[k] <= `PLS_MODE_RST;
            beh_reg[k] <= `PLS_BEH_RST;
         end
         pol_reg <= `PLS_POL_RST;
         drive_reg <= `PLS_DRIVE_RST;
         misc_reg <= `PLS_MISC_RST;
         reg_rdata <= {`PLS_DATA_W{1'b0}};
      end else begin
         if (reg_wr) begin
            if (reg_addr[3:2] == `PLS_GRP_MODE) begin
               mode_reg[reg_addr[1:0]] <= reg_wdata;
            end else if (reg_addr[3:2] == `PLS_GRP_BEH) begin
               beh_reg[reg_addr[1:0]] <= reg_wdata;
            end else if (reg_addr == `PLS_A_POL) begin
               pol_reg <= reg_wdata;
            end else if (reg_addr == `PLS_A_DRIVE) begin
               drive_reg <= reg_wdata;
            end else if (reg_addr == `PLS_A_MISC) begin
               misc_reg <= reg_wdata;
            end
         end
         reg_rdata <= {`PLS_DATA_W{1'b0}};
         if (reg_rd) begin
            if (reg_addr[3:2] == `PLS_GRP_MODE) begin
               reg_rdata <= mode_reg[reg_addr[1:0]];
            end else if (reg_addr[3:2] == `PLS_GRP_BEH) begin
               reg_rdata <= beh_reg[reg_addr[1:0]];
            end else if (reg_addr == `PLS_A_POL) begin
               reg_rdata <= pol_reg;
            end else if (reg_addr == `PLS_A_DRIVE) begin
               reg_rdata <= drive_reg;
            end else if (reg_addr == `PLS_A_MISC) begin
               reg_rdata <= misc_reg;
            end else if (reg_addr == `PLS_A_LIT) begin
               reg_rdata <= lit_reg;
            end
         end
      end
   end

   // Millisecond tick, blink phase and after-reset blink window
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_cnt_reg <= 20'h00000;
         tick_reg <= 1'b0;
         blink_cnt_reg <= 10'h000;
         blink_phase_reg <= 1'b0;
         rblink_cnt_reg <= 10'h000;
         rblink_active_reg <= 1'b1;
      end else begin
         tick_reg <= 1'b0;
         if (tick_cnt_reg == TICK_LAST) begin
            tick_cnt_reg <= 20'h00000;
            tick_reg <= 1'b1;
         end else begin
            tick_cnt_reg <= tick_cnt_reg + 20'h00001;
         end
         if (tick_reg) begin
            if (blink_cnt_reg == `PLS_BLINK_HALF_TICKS - 10'd1) begin
               blink_cnt_reg <= 10'h000;
               blink_phase_reg <= ~blink_phase_reg;
            end else begin
               blink_cnt_reg <= blink_cnt_reg + 10'h001;
            end
            if (rblink_active_reg) begin
               if (rblink_cnt_reg == `PLS_RST_BLINK_TICKS - 10'd1) begin
                  rblink_active_reg <= 1'b0;
               end else begin
                  rblink_cnt_reg <= rblink_cnt_reg + 10'h001;
               end
            end
         end
      end
   end

   // Serial frame snapshot in stream order, four ports of twelve bits
   always @* begin
      frame_next = 48'h000000000000;
      sb_v = 12'h000;
      for (q = 0; q < 4; q = q + 1) begin
         sb_v[11] = ser_one(led_fn(`PLS_M_LINK, link_up[q], link_speed[2*q +: 2],
            link_fiber[q], link_full_duplex[q], collision[q], tx_activity[q],
            rx_activity[q], aneg_fault[q], 1'b0, 1'b0), blink_phase_reg);
         sb_v[10] = ser_one(led_fn(`PLS_M_L1000, link_up[q], link_speed[2*q +: 2],
            link_fiber[q], link_full_duplex[q], collision[q], tx_activity[q],
            rx_activity[q], aneg_fault[q], 1'b0, 1'b0), blink_phase_reg);
         sb_v[9] = ser_one(led_fn(`PLS_M_L100, link_up[q], link_speed[2*q +: 2],
            link_fiber[q], link_full_duplex[q], collision[q], tx_activity[q],
            rx_activity[q], aneg_fault[q], 1'b0, 1'b0), blink_phase_reg);
         sb_v[8] = ser_one(led_fn(`PLS_M_L10, link_up[q], link_speed[2*q +: 2],
            link_fiber[q], link_full_duplex[q], collision[q], tx_activity[q],
            rx_activity[q], aneg_fault[q], 1'b0, 1'b0), blink_phase_reg);
         sb_v[7] = ser_one(led_fn(`PLS_M_LFIBER, link_up[q], link_speed[2*q +: 2],
            link_fiber[q], link_full_duplex[q], collision[q], tx_activity[q],
            rx_activity[q], aneg_fault[q], 1'b0, 1'b0), blink_phase_reg);
         sb_v[6] = ser_one(led_fn(`PLS_M_DUPLEX, link_up[q], link_speed[2*q +: 2],
            link_fiber[q], link_full_duplex[q], collision[q], tx_activity[q],
            rx_activity[q], aneg_fault[q], 1'b0, 1'b0), blink_phase_reg);
         sb_v[5] = collision[q] & blink_phase_reg;
         sb_v[4] = (tx_activity[q] | rx_activity[q]) & blink_phase_reg;
         sb_v[3] = ser_one(led_fn(`PLS_M_FACT, link_up[q], link_speed[2*q +: 2],
            link_fiber[q], link_full_duplex[q], collision[q], tx_activity[q],
            rx_activity[q], aneg_fault[q], 1'b0, 1'b0), blink_phase_reg);
         sb_v[2] = tx_activity[q] & blink_phase_reg;
         sb_v[1] = rx_activity[q] & blink_phase_reg;
         sb_v[0] = aneg_fault[q];
         frame_next[47 - 12*q -: 12] = sb_v;
      end
   end

   // Serial shifter: data changes on the falling edge of the serial clock
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ser_div_reg <= 4'h0;
         ser_clk_reg <= 1'b0;
         ser_idx_reg <= 6'h00;
         ser_sh_reg <= 48'h000000000000;
      end else begin
         if (ser_div_reg == `PLS_SER_HALF_CYC - 4'd1) begin
            ser_div_reg <= 4'h0;
            ser_clk_reg <= ~ser_clk_reg;
            if (ser_clk_reg) begin
               if (ser_idx_reg == `PLS_SER_LAST) begin
                  ser_idx_reg <= 6'h00;
                  ser_sh_reg <= frame_next;
               end else begin
                  ser_idx_reg <= ser_idx_reg + 6'h01;
                  ser_sh_reg <= {ser_sh_reg[46:0], 1'b0};
               end
            end
         end else begin
            ser_div_reg <= ser_div_reg + 4'h1;
         end
      end
   end

   // Per-pin mode decode, animation, polarity and drive state
   always @* begin
      out_next = 16'h0000;
      oe_next = 16'h0000;
      lit_next = 16'h0000;
      anim_next = 16'h0000;
      fn_v = 2'b00;
      m_v = 4'h0;
      pol_v = 1'b0;
      lit_v = 1'b0;
      for (p = 0; p < 16; p = p + 1) begin
         m_v = mode_reg[p / 4][(p % 4) * 4 +: 4];
         fn_v = led_fn(m_v, link_up[p / 4], link_speed[2 * (p / 4) +: 2],
            link_fiber[p / 4], link_full_duplex[p / 4], collision[p / 4],
            tx_activity[p / 4], rx_activity[p / 4], aneg_fault[p / 4],
            beh_reg[p / 4][`PLS_SPLIT_BIT], p < 4);
         anim_next[p] = fn_v[0];
         if (beh_reg[p / 4][p % 4]) begin
            // Stretch inverts the steady state for the first half of its window
            lit_v = fn_v[1] ^ (str_cnt_reg[p] > `PLS_STRETCH_TICKS);
         end else begin
            lit_v = fn_v[0] ? blink_phase_reg : fn_v[1];
         end
         if (rblink_active_reg && misc_reg[`PLS_RBLINK_BIT] &&
             m_v != `PLS_M_OFF && m_v != `PLS_M_ON) begin
            lit_v = blink_phase_reg;
         end
         lit_next[p] = lit_v;
         pol_v = pol_reg[`PLS_POL_LSB + (p % 4)];
         out_next[p] = lit_v ? pol_v : ~pol_v;
         // Inactive level is driven unless drive-state asks for tristate and the enhanced bit is clear
         oe_next[p] = lit_v | ~drive_reg[`PLS_DRV_BIT] | drive_reg[`PLS_ENH_BIT];
         if (p == 0 && m_v == `PLS_M_SERIAL) begin
            out_next[p] = ser_sh_reg[47];
            oe_next[p] = 1'b1;
         end
         if (p == 1 && m_v == `PLS_M_SERIAL) begin
            out_next[p] = ser_clk_reg;
            oe_next[p] = 1'b1;
         end
      end
   end

   // Stretch counters and registered pin outputs
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         for (n = 0; n < 16; n = n + 1) begin
            str_cnt_reg[n] <= 8'h00;
         end
         first_led_pin_group <= 16'hffff;
         led_oe <= 16'h0000;
         lit_reg <= 16'h0000;
      end else begin
         for (n = 0; n < 16; n = n + 1) begin
            if (str_cnt_reg[n] != 8'h00) begin
               if (tick_reg) begin
                  str_cnt_reg[n] <= str_cnt_reg[n] - 8'h01;
               end
            end else if (anim_next[n] && beh_reg[n / 4][n % 4]) begin
               // Full window gives an on time and an off time of equal length
               str_cnt_reg[n] <= `PLS_STRETCH_TICKS + `PLS_STRETCH_TICKS;
            end
         end
         first_led_pin_group <= out_next;
         led_oe <= oe_next;
         lit_reg <= lit_next;
      end
   end

endmodule // pls_led_driver
`default_nettype wire

// ===== shared/pls_defines.vh
// Constants for the per-port LED status driver
`ifndef PLS_DEFINES_VH
`define PLS_DEFINES_VH

// Register map, word index on the local register port
`define PLS_ADDR_W 4
`define PLS_DATA_W 16
`define PLS_GRP_MODE 2'h0
`define PLS_GRP_BEH 2'h1
`define PLS_A_POL 4'h8
`define PLS_A_DRIVE 4'h9
`define PLS_A_MISC 4'ha
`define PLS_A_LIT 4'hb

// Field positions
`define PLS_POL_LSB 10
`define PLS_DRV_BIT 9
`define PLS_ENH_BIT 0
`define PLS_SPLIT_BIT 14
`define PLS_RBLINK_BIT 11

// Reset values
`define PLS_MODE_RST 16'h8210
`define PLS_BEH_RST 16'h0000
`define PLS_POL_RST 16'h0000
`define PLS_DRIVE_RST 16'h0200
`define PLS_MISC_RST 16'h0800

// Mode codes
`define PLS_M_LINK 4'h0
`define PLS_M_L1000 4'h1
`define PLS_M_L100 4'h2
`define PLS_M_L10 4'h3
`define PLS_M_L100_1000 4'h4
`define PLS_M_L10_1000 4'h5
`define PLS_M_L10_100 4'h6
`define PLS_M_LFIBER 4'h7
`define PLS_M_DUPLEX 4'h8
`define PLS_M_COLL 4'h9
`define PLS_M_ACT 4'ha
`define PLS_M_FACT 4'hb
`define PLS_M_ANFAULT 4'hc
`define PLS_M_SERIAL 4'hd
`define PLS_M_OFF 4'he
`define PLS_M_ON 4'hf

// Speed encoding of the status inputs
`define PLS_SPD_10 2'h0
`define PLS_SPD_100 2'h1
`define PLS_SPD_1000 2'h2

// Timing
`define PLS_CLK_NS 10
`define PLS_TICK_NS 1000000
`define PLS_TICK_MS 10'd1
`define PLS_BLINK_HALF_MS 10'd50
`define PLS_BLINK_HALF_TICKS (`PLS_BLINK_HALF_MS / `PLS_TICK_MS)
`define PLS_STRETCH_MS 8'd100
`define PLS_STRETCH_TICKS (`PLS_STRETCH_MS / 8'd1)
`define PLS_RST_BLINK_MS 10'd1000
`define PLS_RST_BLINK_TICKS (`PLS_RST_BLINK_MS / `PLS_TICK_MS)
`define PLS_SER_HALF_NS 80
`define PLS_SER_HALF_CYC 4'd8
`define PLS_SER_BITS 6'd48
`define PLS_SER_LAST 6'd47

`endif

// ===== verification/pls_led_props.sv
// Port assertions for the LED status driver
`timescale 1ns/10ps
`default_nettype none
`include "pls_defines.vh"
module pls_led_props #(
   parameter TICK_CYCLES = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [3:0] link_up,
   input wire logic [7:0] link_speed,
   input wire logic [3:0] link_fiber,
   input wire logic [3:0] link_full_duplex,
   input wire logic [3:0] collision,
   input wire logic [3:0] tx_activity,
   input wire logic [3:0] rx_activity,
   input wire logic [3:0] aneg_fault,
   input wire logic [15:0] first_led_pin_group,
   input wire logic [15:0] led_oe
);
   // Shadow of the settings, so pin checks can follow software changes
   logic [15:0] mode_sh [0:3];
   logic [3:0] pol_sh;
   logic drv_sh;
   logic enh_sh;
   logic [15:0] f_on;
   logic [15:0] f_off;
   wire [15:0] pe = {4{pol_sh}};
   wire [15:0] mode_sel = mode_sh[reg_addr[1:0]];
   wire [1:0] dr2 = {drv_sh, enh_sh};
   integer i;
   integer j;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         for (i = 0; i < 4; i = i + 1)
            mode_sh[i] <= `PLS_MODE_RST;
         pol_sh <= 4'h0;
         drv_sh <= 1'b1;
         enh_sh <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr < 4'h4)
            mode_sh[reg_addr[1:0]] <= reg_wdata;
         if (reg_addr == `PLS_A_POL)
            pol_sh <= reg_wdata[13:10];
         if (reg_addr == `PLS_A_DRIVE) begin
            drv_sh <= reg_wdata[9];
            enh_sh <= reg_wdata[0];
         end
      end
   end
   always @* begin
      for (j = 0; j < 16; j = j + 1) begin
         f_on[j] = mode_sh[j/4][4*(j%4)+:4] == 4'hf;
         f_off[j] = mode_sh[j/4][4*(j%4)+:4] == 4'he;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_reset_idle: assert property (
      $fell(rst) |-> $past(first_led_pin_group) == 16'hffff && $past(led_oe) == 16'h0)
      else $error("pins not idle during reset");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
      else $error("read data outside its cycle");
   a_unmapped_zero: assert property (
      $past(reg_rd) && $past(reg_addr) > 4'hb |-> reg_rdata == 16'h0)
      else $error("unmapped read not zero");
   a_mode_readback: assert property (
      $past(reg_rd) && $past(reg_addr) < 4'h4 |-> reg_rdata == $past(mode_sel))
      else $error("mode readback wrong");
   a_pol_readback: assert property (
      $past(reg_rd) && $past(reg_addr) == 4'h8 |-> reg_rdata[13:10] == $past(pol_sh))
      else $error("polarity readback wrong");
   a_drive_readback: assert property (
      $past(reg_rd) && $past(reg_addr) == 4'h9 |-> {reg_rdata[9], reg_rdata[0]} == $past(dr2))
      else $error("drive readback wrong");
   a_drive_oe: assert property (!$past(drv_sh) || $past(enh_sh) |-> led_oe == 16'hffff)
      else $error("inactive pin not driven");
   a_off_level: assert property (((first_led_pin_group ^ ~$past(pe)) & ~led_oe) == 16'h0)
      else $error("released pin not at inactive level");
   a_force_on: assert property (
      ($past(f_on) & ((first_led_pin_group ^ $past(pe)) | ~led_oe)) == 16'h0)
      else $error("forced-on pin not lit");
   a_force_off: assert property (
      ($past(f_off) & (first_led_pin_group ^ ~$past(pe))) == 16'h0)
      else $error("forced-off pin lit");
   c_lit_read: cover property ($past(reg_rd) && $past(reg_addr) == 4'hb);
   c_driven_idle: cover property (!$past(drv_sh));
   c_blink: cover property ($rose(first_led_pin_group[9]));
endmodule // pls_led_props
`default_nettype wire

// ===== verification/pls_led_load.sv
// LEDs tied from the supply to the pins
`timescale 1ns/10ps
`default_nettype none
module pls_led_load (
   input wire logic [15:0] pin,
   input wire logic [15:0] oe,
   output logic [15:0] level
);
   // A released pin floats up through its LED; it never keeps its last value
   assign level = (pin & oe) | ~oe;
endmodule // pls_led_load
`default_nettype wire

// ===== verification/pls_led_driver_tb_top.sv
// Self-checking bench for the LED status driver
`timescale 1ns/10ps
`default_nettype none
`include "pls_defines.vh"
module pls_led_driver_tb_top;
   logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, chk = 0, rd_d = 0, obs_v = 0;
   logic [3:0] reg_addr = 0, lu = 0, fb = 0, fd = 0, co = 0, tx = 0, rx = 0, af = 0;
   logic [7:0] sp = 0;
   logic [15:0] reg_wdata = 0, reg_rdata, pins, oe, lvl;
   logic [31:0] seed = 26, obs = 0;
   logic [63:0] q[$];
   int fails = 0, cmp_count = 0;
   pls_led_driver #(.TICK_CYCLES(10)) pls_led_driver_i (.clk(clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .link_up(lu), .link_speed(sp), .link_fiber(fb),
      .link_full_duplex(fd), .collision(co), .tx_activity(tx), .rx_activity(rx),
      .aneg_fault(af), .first_led_pin_group(pins), .led_oe(oe));
   pls_led_load pls_led_load_i (.pin(pins), .oe(oe), .level(lvl));
   initial begin
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] nxt();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic lit_of(input logic [3:0] m, input logic l, f, d, a,
      input logic [1:0] s);
      case (m)
         4'h0: return l;
         4'h1: return l && s == 2'h2;
         4'h2: return l && s == 2'h1;
         4'h3: return l && s == 2'h0;
         4'h4: return l && s != 2'h0;
         4'h5: return l && s != 2'h1;
         4'h6: return l && s != 2'h2;
         4'h7: return l && f;
         4'h8: return l && d;
         4'hc: return a;
         4'hf: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_rd <= 1'b0;
      reg_wr <= 1'b1;
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      q.push_back({32'hffffffff, 16'h0, e});
      reg_addr <= a;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk);
   endtask
   task automatic idle();
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic expect_pins(input int n, input logic [15:0] el, eo, mk);
      repeat (n) @(posedge clk);
      q.push_back({mk, mk, el, eo});
      chk <= 1'b1;
      @(posedge clk);
      chk <= 1'b0;
      @(posedge clk);
   endtask
   // Counts toggles after a settle time; blink and serial clock periods are exact
   task automatic watch(input logic [31:0] e);
      logic [15:0] p0;
      logic [7:0] c1, c8, c9, c10;
      {c1, c8, c9, c10} = 32'h0;
      repeat (600) @(posedge clk);
      p0 = pins;
      repeat (2000) begin
         @(posedge clk);
         c1 += {7'h0, pins[1] ^ p0[1]};
         c8 += {7'h0, pins[8] ^ p0[8]};
         c9 += {7'h0, pins[9] ^ p0[9]};
         c10 += {7'h0, pins[10] ^ p0[10]};
         p0 = pins;
      end
      q.push_back({32'hffffffff, e});
      obs <= {c1, c10, c9, c8};
      obs_v <= 1'b1;
      @(posedge clk);
      obs_v <= 1'b0;
      @(posedge clk);
   endtask
   task automatic cmp(input logic [31:0] g);
      logic [63:0] e;
      e = q.pop_front();
      cmp_count++;
      if ((g & e[63:32]) !== e[31:0]) begin
         fails++;
         $display("FAIL t=%0t got %h exp %h", $time, g & e[63:32], e[31:0]);
      end
   endtask
   always @(posedge clk) begin
      rd_d <= reg_rd;
      if (rd_d)
         cmp({16'h0, reg_rdata});
      if (chk)
         cmp({lvl, oe});
      if (obs_v)
         cmp(obs);
   end
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #900000;
      fails++;
      complete_run();
   end
   initial begin
      logic [15:0] m [4];
      logic [15:0] el, eo, lit;
      logic [1:0] s [4];
      logic [31:0] r;
      logic [3:0] lk, fdx, afl, fbr, pl;
      logic dv, en;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int a = 0; a < 13; a++)
         if (a != 11)
            rd(a[3:0], a < 4 ? `PLS_MODE_RST : a == 9 ? `PLS_DRIVE_RST : a == 10 ? `PLS_MISC_RST : 16'h0);
      wr(4'hc, 16'hffff);
      rd(4'hc, 16'h0);
      for (int p = 0; p < 4; p++)
         wr(p[3:0], 16'hfefe);
      idle();
      // Checked while the after-reset blink is still running
      repeat (3) expect_pins(300, 16'h5555, 16'haaaa, 16'hffff);
      $display("reset and force test done");
      repeat (10500) @(posedge clk);
      for (int k = 0; k < 40; k++) begin
         r = nxt();
         {pl, fbr, afl, fdx, lk} = r[19:0];
         dv = r[20];
         en = r[21] & r[22];
         for (int p = 0; p < 4; p++) begin
            s[p] = r[24+2*p+:2] == 2'h3 ? 2'h2 : r[24+2*p+:2];
            if (fbr[p] && s[p] == 2'h0)
               s[p] = 2'h1;
         end
         lu <= lk;
         fd <= fdx;
         af <= afl;
         fb <= fbr;
         sp <= {s[3], s[2], s[1], s[0]};
         for (int p = 0; p < 4; p++) begin
            r = nxt();
            m[p] = r[15:0];
            if (p == 0 && m[0][3:0] == 4'hd)
               m[0][3:0] = 4'he;
            if (p == 0 && m[0][7:4] == 4'hd)
               m[0][7:4] = 4'he;
            wr(p[3:0], m[p]);
         end
         wr(4'h8, {2'h0, pl, 10'h0});
         wr(4'h9, {6'h0, dv, 8'h0, en});
         idle();
         for (int p = 0; p < 16; p++) begin
            lit[p] = lit_of(m[p/4][4*(p%4)+:4], lk[p/4], fbr[p/4], fdx[p/4], afl[p/4], s[p/4]);
            eo[p] = lit[p] | ~dv | en;
            el[p] = eo[p] ? ~(lit[p] ^ pl[p%4]) : 1'b1;
         end
         expect_pins(3, el, eo, 16'hffff);
         rd(4'hb, lit);
         idle();
      end
      $display("static mode test done");
      {lu, fb, sp, tx, rx, fd, af} <= {4'hf, 4'h4, 8'h20, 4'h4, 4'h4, 8'h0};
      wr(4'h0, 16'h00dd);
      wr(4'h2, 16'h09ba);
      wr(4'h8, 16'h0);
      wr(4'h9, 16'h0200);
      idle();
      // Port 0 LED2/3 stay ordinary link LEDs beside the serial pins
      expect_pins(3, 16'h0000, 16'h000c, 16'h000c);
      watch(32'hfa000404);
      wr(4'h6, 16'h4004);
      idle();
      tx <= 4'h0;
      co <= 4'h4;
      @(posedge clk);
      co <= 4'h0;
      expect_pins(30, 16'h0000, 16'h0400, 16'h0400);
      expect_pins(1200, 16'h0400, 16'h0000, 16'h0400);
      watch(32'hfa000400);
      $display("animation test done");
      complete_run();
   end
endmodule // pls_led_driver_tb_top
bind pls_led_driver pls_led_props #(.TICK_CYCLES(TICK_CYCLES)) pls_led_props_i (.clk(clk),
   .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .link_up(link_up), .link_speed(link_speed),
   .link_fiber(link_fiber), .link_full_duplex(link_full_duplex), .collision(collision),
   .tx_activity(tx_activity), .rx_activity(rx_activity), .aneg_fault(aneg_fault),
   .first_led_pin_group(first_led_pin_group), .led_oe(led_oe));
`default_nettype wire
